// [css_top.sv]
// clock source selection and two-speed start-up with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "css_regs.svh"
module css_top #(
  parameter int AW = `CSS_ADDR_W,
  parameter int STARTUP_COUNT = `CSS_STARTUP_COUNT,
  parameter int WARM_CYC = `CSS_WARM_CYC,
  parameter int LF_CYC = `CSS_LF_CYC
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [AW-1:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output css_pkg::css_resp_t bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [AW-1:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output css_pkg::css_resp_t rresp_o,
  input wire logic powerup_done_i,
  input wire logic sleep_req_i,
  input wire logic wake_i,
  input wire logic ext_osc_i,
  input wire logic gpio_do_i,
  input wire logic gpio_oe_i,
  output logic clkin_gpio_o,
  output logic clkout_pin_o,
  output logic clkout_pin_oe_o,
  output logic cpu_run_o,
  output logic sys_src_ext_o,
  output logic sys_clk_en_o
);
  import css_pkg::*;

  logic [7:0] oscillator_control_reg; // system select and internal source select
  logic [5:0] frequency_trim_reg; // signed trim of the mid and high clocks
  logic [7:0] osc_config; // mode, switchover, clock output disable, failsafe
  logic startup_done_flag; // set when the external crystal is qualified
  css_state_t state; // start-up sequencer
  css_state_t next_state;
  logic [7:0] warm_cnt; // cycles spent warming the internal source
  logic ext_q; // previous external oscillator level
  logic clkout_q; // divided clock shown on the output pin
  logic aw_got, w_got; // write halves captured
  logic [AW-1:0] wa; // captured write address
  logic [7:0] wd; // captured write byte
  logic ws; // low byte lane enabled
  logic wr_fire; // both halves present, answer not yet given
  logic mf_t, hf_t, lf_t; // internal oscillator ticks
  logic [9:0] mf_per, hf_per, hf_raw;
  logic signed [11:0] mf_s;
  logic start_done; // start-up timer has seen the full count

  // register decode, shared by the read and the write path
  function automatic logic [2:0] reg_idx(input logic [AW-1:0] a);
    if (a == AW'(`CSS_CTRL_OFS)) reg_idx = `CSS_IX_CTRL;
    else if (a == AW'(`CSS_TRIM_OFS)) reg_idx = `CSS_IX_TRIM;
    else if (a == AW'(`CSS_STAT_OFS)) reg_idx = `CSS_IX_STAT;
    else if (a == AW'(`CSS_CFG_OFS)) reg_idx = `CSS_IX_CFG;
    else reg_idx = `CSS_IX_NONE;
  endfunction : reg_idx

  // field views of the control and configuration registers
  wire logic [1:0] sys_clock_select = oscillator_control_reg[1:0];
  wire logic [1:0] int_sel = oscillator_control_reg[5:4];
  wire css_mode_t osc_mode_config = osc_config[2:0];
  wire logic switchover_enable_cfg = osc_config[3];
  wire logic clock_output_disable_cfg = osc_config[4];
  wire logic failsafe_clock_monitor = osc_config[5];

  wire logic mode_xtal = (osc_mode_config == `CSS_M_LOWPWR) || (osc_mode_config == `CSS_M_CRYSTAL) ||
    (osc_mode_config == `CSS_M_HISPEED);
  wire logic mode_int = (osc_mode_config == `CSS_M_INT);
  // two-speed only for crystal modes with select 00; failsafe forces the enable
  wire logic two_speed = (switchover_enable_cfg || failsafe_clock_monitor) &&
    (sys_clock_select == `CSS_SEL_CFG) && mode_xtal;
  // an upper select bit overrides the configured source at run time
  wire logic ext_path = !sys_clock_select[1] && !mode_int;
  wire logic src_ext = ext_path && (!mode_xtal || startup_done_flag);
  // crystal without two-speed: the core is held until the count finishes
  wire logic hold = ext_path && mode_xtal && !two_speed && !startup_done_flag;
  wire logic need_int = !ext_path || two_speed;
  wire logic ext_edge = ext_osc_i && !ext_q;
  wire logic start_en = (state == ST_RUN) && ext_path && mode_xtal;
  // the count restarts whenever the sequencer leaves the running state
  wire logic start_clr = (state != ST_RUN) || sleep_req_i;
  wire logic warm_done = !need_int || (warm_cnt == 8'(WARM_CYC - 1));
  wire logic int_tick = (int_sel == `CSS_ISEL_HF) ? hf_t : (int_sel == `CSS_ISEL_MF) ? mf_t : lf_t;

  // mid clock period follows the signed trim, clamped to at least one cycle
  assign mf_s = 12'(`CSS_MF_CYC) + {{6{frequency_trim_reg[5]}}, frequency_trim_reg};
  assign mf_per = (mf_s[11] || mf_s == 12'h000) ? 10'h001 : mf_s[9:0];
  // the high clock is the trimmed mid clock times the loop ratio; at this
  // reference rate it saturates at one tick per cycle
  assign hf_raw = mf_per / 10'(`CSS_PLL_MUL);
  assign hf_per = (hf_raw == 10'h000) ? 10'h001 : hf_raw;
  assign wr_fire = aw_got && w_got && !bvalid_o;

  css_osc_tick #(.CW(10)) u_mf (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .period_i(mf_per), .tick_o(mf_t));
  css_osc_tick #(.CW(10)) u_hf (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .period_i(hf_per), .tick_o(hf_t));
  // low clock: own divider, no trim input, so it never follows the mid clock
  css_osc_tick #(.CW(10)) u_lf (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .period_i(10'(LF_CYC)),
    .tick_o(lf_t));
  css_start_timer #(.COUNT(STARTUP_COUNT)) u_start (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clr_i(start_clr),
    .en_i(start_en), .edge_i(ext_edge), .done_o(start_done));

  // sequencer: power-up wait, warm-up, running, sleeping
  always_comb begin
    next_state = state;
    case (state)
      ST_POWERUP: if (powerup_done_i) next_state = ST_WARM;
      ST_WARM: if (warm_done) next_state = ST_RUN;
      ST_RUN: if (sleep_req_i) next_state = ST_SLEEP;
      ST_SLEEP: if (wake_i) next_state = ST_WARM;
      default: next_state = ST_POWERUP;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) state <= ST_POWERUP;
    else state <= next_state;
  end

  // warm-up counter runs only while warming
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) warm_cnt <= 8'h00;
    else if (state != ST_WARM) warm_cnt <= 8'h00;
    else warm_cnt <= 8'(warm_cnt + 1'b1);
  end

  // status flag: sleep wins so an aborted start leaves it clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) startup_done_flag <= 1'b0;
    else if (sleep_req_i && state == ST_RUN) startup_done_flag <= 1'b0;
    else if (start_en && start_done) startup_done_flag <= 1'b1;
  end

  // core-facing outputs, all registered
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_q <= 1'b0;
      cpu_run_o <= 1'b0;
      sys_src_ext_o <= 1'b0;
      sys_clk_en_o <= 1'b0;
    end else begin
      ext_q <= ext_osc_i;
      cpu_run_o <= (state == ST_RUN) && !hold;
      sys_src_ext_o <= (state == ST_RUN) && src_ext;
      sys_clk_en_o <= (state == ST_RUN) && !hold && (src_ext ? ext_edge : int_tick);
    end
  end

  // pins: in internal mode the input pin is free and the output pin shows clock or port data
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clkout_q <= 1'b0;
      clkin_gpio_o <= 1'b0;
      clkout_pin_o <= 1'b0;
      clkout_pin_oe_o <= 1'b0;
    end else begin
      if (int_tick) clkout_q <= !clkout_q;
      clkin_gpio_o <= mode_int;
      if (mode_int && !clock_output_disable_cfg) begin
        clkout_pin_o <= clkout_q;
        clkout_pin_oe_o <= 1'b1;
      end else begin
        clkout_pin_o <= gpio_do_i;
        clkout_pin_oe_o <= gpio_oe_i;
      end
    end
  end

  // write channels: address and data taken in either order, one write at a time
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      bvalid_o <= 1'b0;
      bresp_o <= `CSS_RESP_OK;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      wa <= '0;
      wd <= 8'h00;
      ws <= 1'b0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_got <= 1'b1;
        wa <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_got <= 1'b1;
        wd <= wdata_i[7:0];
        ws <= wstrb_i[0];
        wready_o <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_o <= 1'b1;
        bresp_o <= (reg_idx(wa) == `CSS_IX_NONE) ? `CSS_RESP_ERR : `CSS_RESP_OK;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // register writes land at the edge that raises the write answer
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oscillator_control_reg <= `CSS_CTRL_RST;
      frequency_trim_reg <= `CSS_TRIM_RST;
      osc_config <= `CSS_CFG_RST;
    end else if (wr_fire && ws) begin
      if (reg_idx(wa) == `CSS_IX_CTRL) oscillator_control_reg <= wd & `CSS_CTRL_MASK;
      else if (reg_idx(wa) == `CSS_IX_TRIM) frequency_trim_reg <= wd[5:0];
      else if (reg_idx(wa) == `CSS_IX_CFG) osc_config <= wd & `CSS_CFG_MASK;
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= `CSS_RESP_OK;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rresp_o <= `CSS_RESP_OK;
      if (reg_idx(araddr_i) == `CSS_IX_CTRL) rdata_o <= {24'h00_0000, oscillator_control_reg};
      else if (reg_idx(araddr_i) == `CSS_IX_TRIM) rdata_o <= {26'h000_0000, frequency_trim_reg};
      else if (reg_idx(araddr_i) == `CSS_IX_STAT) rdata_o <= {26'h000_0000, state, cpu_run_o,
        two_speed, sys_src_ext_o, startup_done_flag};
      else if (reg_idx(araddr_i) == `CSS_IX_CFG) rdata_o <= {24'h00_0000, osc_config};
      else begin
        rdata_o <= 32'h0000_0000;
        rresp_o <= `CSS_RESP_ERR;
      end
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence wake_s;
    state == ST_SLEEP && wake_i;
  endsequence
  sequence warm_hold_s;
    state == ST_WARM ##1 !cpu_run_o;
  endsequence

  int_mode_a: assert property (mode_int && state == ST_RUN |=> !sys_src_ext_o)
    else $error("internal mode ran external");
  sel_int_a: assert property (sys_clock_select[1] |=> !sys_src_ext_o)
    else $error("select did not force internal");
  pin_free_a: assert property (mode_int && !clock_output_disable_cfg |=> clkin_gpio_o && clkout_pin_oe_o)
    else $error("internal mode pins wrong");
  // while the mid period is under twice the loop ratio the high clock must tick every cycle
  hf_ratio_a: assert property (mf_per < 10'(2 * `CSS_PLL_MUL) |=> hf_t)
    else $error("high clock slower than mid clock times loop ratio");
  ts_off_a: assert property (!mode_xtal |-> !two_speed)
    else $error("two-speed outside crystal modes");
  ts_run_a: assert property (two_speed && state == ST_RUN && !startup_done_flag && !sleep_req_i
    |=> cpu_run_o && !sys_src_ext_o) else $error("two-speed not running internal");
  flag_set_a: assert property ($rose(startup_done_flag) |-> $past(start_done) ##1 sys_src_ext_o || !ext_path)
    else $error("flag set without count or no changeover");
  sleep_clr_a: assert property (sleep_req_i && state == ST_RUN |=> !startup_done_flag [*2])
    else $error("sleep left flag set");
  wake_warm_a: assert property (wake_s |=> warm_hold_s)
    else $error("wake did not warm up");
  fs_force_a: assert property (failsafe_clock_monitor && mode_xtal && sys_clock_select == `CSS_SEL_CFG
    |-> two_speed) else $error("failsafe did not enable two-speed");
endmodule : css_top

// [css_regs.svh]
// register map, field codes, reset values and timing counts of the clock source block
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH
// bus address width and register byte offsets
`define CSS_ADDR_W 8
`define CSS_CTRL_OFS 8'h00
`define CSS_TRIM_OFS 8'h04
`define CSS_STAT_OFS 8'h08
`define CSS_CFG_OFS 8'h0C
// internal register index codes
`define CSS_IX_CTRL 3'h0
`define CSS_IX_TRIM 3'h1
`define CSS_IX_STAT 3'h2
`define CSS_IX_CFG 3'h3
`define CSS_IX_NONE 3'h4
// writable bits and reset values
`define CSS_CTRL_MASK 8'h33
`define CSS_CFG_MASK 8'h3F
`define CSS_CTRL_RST 8'h00
`define CSS_TRIM_RST 6'h00
`define CSS_CFG_RST 8'h04
// oscillator mode codes held in the configuration register
`define CSS_M_LOWPWR 3'h0
`define CSS_M_CRYSTAL 3'h1
`define CSS_M_HISPEED 3'h2
`define CSS_M_INT 3'h4
// system clock select and internal source select codes
`define CSS_SEL_CFG 2'h0
`define CSS_ISEL_HF 2'h0
`define CSS_ISEL_MF 2'h1
// bus responses
`define CSS_RESP_OK 2'h0
`define CSS_RESP_ERR 2'h2
// rates and times
`define CSS_CLK_HZ 10000000
`define CSS_CLK_NS 100
`define CSS_MF_HZ 500000
`define CSS_HF_HZ 16000000
`define CSS_LF_HZ 31000
`define CSS_PLL_MUL (`CSS_HF_HZ / `CSS_MF_HZ)
`define CSS_MF_CYC (`CSS_CLK_HZ / `CSS_MF_HZ)
`define CSS_LF_CYC (`CSS_CLK_HZ / `CSS_LF_HZ)
`define CSS_TWARM_NS 2000
`define CSS_WARM_CYC ((`CSS_TWARM_NS + `CSS_CLK_NS - 1) / `CSS_CLK_NS)
`define CSS_STARTUP_COUNT 1024
`endif

// [css_pkg.sv]
// types shared by the clock source block
package css_pkg;
  typedef logic [1:0] css_resp_t;
  typedef logic [2:0] css_mode_t;
  typedef enum logic [1:0] {ST_POWERUP, ST_WARM, ST_RUN, ST_SLEEP} css_state_t;
endpackage : css_pkg

// [css_osc_tick.sv]
// one oscillator modelled as a one-cycle tick at a programmable period
`timescale 1ns/100ps
module css_osc_tick #(
  parameter int CW = 10
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [CW-1:0] period_i,
  output logic tick_o
);
  import css_pkg::*;
  logic [CW-1:0] cnt; // cycles since last tick

  // period of zero is treated like one by the caller, never here
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt >= CW'(period_i - 1'b1)) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= CW'(cnt + 1'b1);
      tick_o <= 1'b0;
    end
  end
endmodule : css_osc_tick

// [css_start_timer.sv]
// start-up timer counting external oscillator edges
`timescale 1ns/100ps
module css_start_timer #(
  parameter int COUNT = 1024
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic edge_i,
  output logic done_o
);
  import css_pkg::*;
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt; // external edges seen so far

  // clear wins over counting so an aborted count never carries over
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else if (clr_i) begin
      cnt <= '0;
      done_o <= 1'b0;
    end else if (en_i && edge_i && !done_o) begin
      cnt <= CW'(cnt + 1'b1);
      done_o <= (cnt == CW'(COUNT - 1));
    end
  end

  clr_zero_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clr_i |=> (cnt == '0) && !done_o) else $error("start timer not cleared");
  done_count_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    $rose(done_o) |-> cnt == CW'(COUNT)) else $error("start timer done at wrong count");
endmodule : css_start_timer

// [css_xtal_model.sv]
// behavioural external crystal: bursts of oscillations, standing still between bursts
`timescale 1ns/100ps
module css_xtal_model (
  input wire logic ref_clk_i,
  input wire logic go_i, // load a new burst
  input wire logic [15:0] count_i, // oscillations in the burst
  input wire logic [3:0] half_i, // half period in reference cycles, prompt or slow
  output logic osc_o,
  output logic busy_o
);
  int left = 0; // oscillations still to send
  int ph = 0; // position inside one oscillation
  initial osc_o = 1'b0;
  assign busy_o = (left != 0);
  // a stopped crystal sits low, so no stray edge reaches the start-up timer between bursts
  always @(posedge ref_clk_i) begin
    if (go_i) begin
      left <= count_i;
      ph <= 0;
    end else if (left != 0) begin
      osc_o <= (ph < half_i);
      // one full period ends here, so one oscillation is spent
      if (ph == 2 * half_i - 1) begin
        ph <= 0;
        left <= left - 1;
      end else begin
        ph <= ph + 1;
      end
    end else begin
      osc_o <= 1'b0;
    end
  end
endmodule : css_xtal_model

// [css_top_tb.sv]
// self-checking bench for the clock source block: bus, start-up sequencing and pins
`timescale 1ns/100ps
`include "css_regs.svh"
module css_top_tb;
  import css_pkg::*;
  localparam int START_CNT = 8; // short start-up count keeps the run brief
  localparam int LF = 4; // short low clock period
  localparam logic [7:0] CFGS [7] = '{8'h09, 8'h08, 8'h0A, 8'h01, 8'h21, 8'h09, 8'h09}; // crystal cases
  localparam logic [6:0] SEL_INT = 7'b0100000; // cases that force the internal select
  localparam logic [6:0] MIDS = 7'b1110111; // cases that execute during the count
  localparam logic [6:0] FINS = 7'b1011111; // cases that end on the external clock
  localparam logic [6:0] ABORTS = 7'b0000100; // case with a sleep in mid-count
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [3:0] wstrb_i = 4'h0;
  logic powerup_done_i = 1'b0, sleep_req_i = 1'b0, wake_i = 1'b0, gpio_do_i = 1'b0, gpio_oe_i = 1'b0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, ext_osc_i;
  logic clkin_gpio_o, clkout_pin_o, clkout_pin_oe_o, cpu_run_o, sys_src_ext_o, sys_clk_en_o;
  logic [31:0] rdata_o;
  css_resp_t bresp_o, rresp_o;
  logic go = 1'b0; // partner burst strobe
  logic [15:0] cnt = 16'h0;
  logic [3:0] half = 4'h2;
  logic busy;
  int n_errors = 0, n_compared = 0, cycles = 0, t = 0, p = 0;
  css_resp_t exp_b[$], exp_rr[$]; // expected responses, oldest first
  logic [31:0] exp_rd[$], exp_rm[$]; // expected read data and compare masks

  css_top #(.STARTUP_COUNT(START_CNT), .WARM_CYC(2), .LF_CYC(LF)) uut (.ref_clk_i, .nrst_i, .awvalid_i,
    .awready_o, .awaddr_i, .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i,
    .arready_o, .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .powerup_done_i, .sleep_req_i, .wake_i,
    .ext_osc_i, .gpio_do_i, .gpio_oe_i, .clkin_gpio_o, .clkout_pin_o, .clkout_pin_oe_o, .cpu_run_o,
    .sys_src_ext_o, .sys_clk_en_o);
  css_xtal_model xtal (.ref_clk_i, .go_i(go), .count_i(cnt), .half_i(half), .osc_o(ext_osc_i), .busy_o(busy));

  // 10 MHz reference
  always #50 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // write: address and data offered together, each released when its own ready is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input css_resp_t r);
    logic aw_ok;
    logic w_ok;
    exp_b.push_back(r);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk_i);
    awvalid_i <= 1'b1;
    awaddr_i <= a;
    wvalid_i <= 1'b1;
    wdata_i <= d;
    wstrb_i <= s;
    bready_i <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk_i);
      if (!aw_ok && awready_o === 1'b1) begin
        aw_ok = 1'b1;
        awvalid_i <= 1'b0;
      end
      if (!w_ok && wready_o === 1'b1) begin
        w_ok = 1'b1;
        wvalid_i <= 1'b0;
      end
    end
    while (bvalid_o !== 1'b1) @(posedge ref_clk_i);
    bready_i <= 1'b0;
  endtask : axi_wr

  // read: only the bits under the mask are compared, for status fields left open
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input css_resp_t r);
    exp_rd.push_back(d);
    exp_rm.push_back(m);
    exp_rr.push_back(r);
    @(posedge ref_clk_i);
    arvalid_i <= 1'b1;
    araddr_i <= a;
    rready_i <= 1'b1;
    do @(posedge ref_clk_i); while (arready_o !== 1'b1);
    arvalid_i <= 1'b0;
    do @(posedge ref_clk_i); while (rvalid_o !== 1'b1);
    rready_i <= 1'b0;
  endtask : axi_rd

  // watcher: each response handshake retires the oldest note
  always @(posedge ref_clk_i) begin
    logic [31:0] m;
    if (bvalid_o === 1'b1 && bready_i === 1'b1 && exp_b.size() > 0)
      check(32'(bresp_o), 32'(exp_b.pop_front()));
    if (rvalid_o === 1'b1 && rready_i === 1'b1 && exp_rd.size() > 0) begin
      m = exp_rm.pop_front();
      check(32'(rresp_o), 32'(exp_rr.pop_front()));
      check(rdata_o & m, exp_rd.pop_front() & m);
    end
  end

  // one-cycle sleep or wake event
  task automatic pulse(input bit w);
    @(posedge ref_clk_i);
    if (w)
      wake_i <= 1'b1;
    else
      sleep_req_i <= 1'b1;
    @(posedge ref_clk_i);
    wake_i <= 1'b0;
    sleep_req_i <= 1'b0;
  endtask : pulse

  // n oscillations at a random pace, then a few cycles for the sampler to settle
  task automatic burst(input int n);
    @(posedge ref_clk_i);
    go <= 1'b1;
    cnt <= 16'(n);
    half <= 4'($urandom_range(5, 2));
    @(posedge ref_clk_i);
    go <= 1'b0;
    do @(posedge ref_clk_i); while (busy);
    repeat (4) @(posedge ref_clk_i);
  endtask : burst

  // cycles between system clock ticks, after the source has settled
  task automatic period(output int q);
    repeat (3) begin
      do @(posedge ref_clk_i); while (sys_clk_en_o !== 1'b1);
    end
    q = 0;
    do begin
      @(posedge ref_clk_i);
      q++;
    end while (sys_clk_en_o !== 1'b1);
  endtask : period

  // sleep, wake, then a start-up count one short and then complete
  task automatic scen(input logic [7:0] cfg, input logic [7:0] ctl, input logic mid, input logic fin, input bit ab);
    axi_wr(`CSS_CTRL_OFS, {24'h0, ctl}, 4'hF, `CSS_RESP_OK);
    axi_wr(`CSS_CFG_OFS, {24'h0, cfg}, 4'hF, `CSS_RESP_OK);
    pulse(0);
    repeat (3) @(posedge ref_clk_i);
    check(cpu_run_o, 1'b0);
    axi_rd(`CSS_STAT_OFS, 32'h30, 32'h31, `CSS_RESP_OK);
    pulse(1);
    if (ab) begin
      burst(5);
      pulse(0);
      axi_rd(`CSS_STAT_OFS, 32'h30, 32'h31, `CSS_RESP_OK);
      pulse(1);
    end
    burst(START_CNT - 1);
    check(sys_src_ext_o, 1'b0);
    check(cpu_run_o, mid);
    if (ctl == 8'h00)
      check(clkin_gpio_o, 1'b0);
    burst(1);
    check(sys_src_ext_o, fin);
    check(cpu_run_o, 1'b1);
    axi_rd(`CSS_STAT_OFS, fin ? 32'h2B : 32'h28, 32'h3B, `CSS_RESP_OK);
  endtask : scen

  // hang guard, far above the expected thousand or so cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    void'($urandom(87298));
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    check(cpu_run_o, 1'b0);
    axi_rd(`CSS_CTRL_OFS, 32'h0, 32'hFFFFFFFF, `CSS_RESP_OK);
    axi_rd(`CSS_TRIM_OFS, 32'h0, 32'hFFFFFFFF, `CSS_RESP_OK);
    axi_rd(`CSS_CFG_OFS, 32'h04, 32'hFFFFFFFF, `CSS_RESP_OK);
    axi_rd(`CSS_STAT_OFS, 32'h0, 32'h3F, `CSS_RESP_OK);
    axi_rd(8'h10, 32'h0, 32'hFFFFFFFF, `CSS_RESP_ERR);
    axi_wr(8'h10, 32'hFF, 4'hF, `CSS_RESP_ERR);
    axi_wr(`CSS_STAT_OFS, 32'hFF, 4'hF, `CSS_RESP_OK);
    axi_wr(`CSS_CTRL_OFS, 32'h11, 4'hE, `CSS_RESP_OK);
    axi_rd(`CSS_CTRL_OFS, 32'h0, 32'hFFFFFFFF, `CSS_RESP_OK);
    done("reset");
    // power-up onto the internal clock, with the warm-up wait first
    @(posedge ref_clk_i);
    powerup_done_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(cpu_run_o, 1'b0);
    repeat (10) if (cpu_run_o !== 1'b1) @(posedge ref_clk_i);
    check(cpu_run_o, 1'b1);
    check(sys_src_ext_o, 1'b0);
    check(clkin_gpio_o, 1'b1);
    check(clkout_pin_oe_o, 1'b1);
    axi_rd(`CSS_STAT_OFS, 32'h28, 32'h3F, `CSS_RESP_OK);
    done("power-up");
    // internal sources under a random trim: only the mid clock moves
    t = int'($urandom_range(16)) - 8;
    axi_wr(`CSS_TRIM_OFS, 32'(t) & 32'h3F, 4'hF, `CSS_RESP_OK);
    axi_rd(`CSS_TRIM_OFS, 32'(t) & 32'h3F, 32'hFFFFFFFF, `CSS_RESP_OK);
    for (int i = 0; i < 3; i++) begin
      axi_wr(`CSS_CTRL_OFS, 32'(i * 16 + 2), 4'hF, `CSS_RESP_OK);
      period(p);
      check(32'(p), i == 0 ? 32'h1 : (i == 1 ? 32'(`CSS_MF_CYC + t) : 32'(LF)));
    end
    axi_rd(`CSS_CTRL_OFS, 32'h22, 32'hFFFFFFFF, `CSS_RESP_OK);
    done("sources");
    // output pin handed back to the port logic
    axi_wr(`CSS_CFG_OFS, 32'h14, 4'hF, `CSS_RESP_OK);
    repeat (4) begin
      @(posedge ref_clk_i);
      gpio_do_i <= 1'($urandom);
      gpio_oe_i <= 1'($urandom);
      repeat (3) @(posedge ref_clk_i);
      check(clkout_pin_o, gpio_do_i);
      check(clkout_pin_oe_o, gpio_oe_i);
    end
    done("pins");
    for (int i = 0; i < 7; i++)
      scen(CFGS[i], SEL_INT[i] ? 8'h02 : 8'h00, MIDS[i], FINS[i], ABORTS[i]);
    done("two-speed");
    // software select back to internal while on the crystal
    axi_wr(`CSS_CTRL_OFS, 32'h02, 4'hF, `CSS_RESP_OK);
    repeat (4) @(posedge ref_clk_i);
    check(sys_src_ext_o, 1'b0);
    check(cpu_run_o, 1'b1);
    // external clock mode never waits on the start-up count
    axi_wr(`CSS_CTRL_OFS, 32'h00, 4'hF, `CSS_RESP_OK);
    axi_wr(`CSS_CFG_OFS, 32'h0B, 4'hF, `CSS_RESP_OK);
    pulse(0);
    pulse(1);
    repeat (8) @(posedge ref_clk_i);
    check(sys_src_ext_o, 1'b1);
    check(cpu_run_o, 1'b1);
    axi_rd(`CSS_STAT_OFS, 32'h0, 32'h04, `CSS_RESP_OK);
    done("switching");
    final_report();
  end
endmodule : css_top_tb
